// ==== watchdog_pkg.sv ====
// Shared constants and types of the watchdog block
package watchdog_pkg;

   // Block base and register indices, kept as printed offsets
   localparam logic [31:0] BLOCK_BASE      = 32'h50003100;
   localparam logic [31:0] COUNT_INDEX     = 32'h50003100 - BLOCK_BASE;
   localparam logic [31:0] CONTROL_INDEX   = 32'h50003102 - BLOCK_BASE;
   // Extra registers of this block (freeze, events)
   localparam logic [31:0] FRZ_SET_INDEX   = 32'h00000004;
   localparam logic [31:0] FRZ_CLR_INDEX   = 32'h00000005;
   localparam logic [31:0] STATUS_INDEX    = 32'h00000006;
   localparam logic [31:0] MASK_INDEX      = 32'h00000007;

   // Byte address is four times the index, within the block window
   localparam int          ADDR_LSB        = 2;
   localparam int          INDEX_BITS      = 4;

   // Count register field layout
   localparam int          KEY_HI          = 15;
   localparam int          KEY_LO          = 9;
   localparam int          SIGN_POS        = 8;
   localparam int          CNT_BITS        = 9;
   localparam logic [6:0]  KEY_OPEN        = 7'h00;

   // Control, freeze and event bit positions
   localparam int          SELECT_POS      = 0;
   localparam int          FREEZE_POS      = 3;
   localparam int          EVT_NMI_POS     = 0;
   localparam int          EVT_RST_POS     = 1;
   localparam int          EVT_BITS        = 2;

   // Counter values of interest
   localparam logic [8:0]  CNT_RESET       = 9'h0ff;
   localparam logic [8:0]  CNT_RELOAD      = 9'h0ff;
   localparam logic [8:0]  CNT_ZERO        = 9'h000;
   localparam logic [8:0]  CNT_MINUS16     = 9'h1f0;
   localparam logic [8:0]  CNT_STEP        = 9'h001;
   localparam logic        SELECT_RESET    = 1'b0;

   // Decrement period
   localparam int          CLK_PERIOD_NS   = 50;
   localparam int          TICK_PERIOD_NS  = 10_240_000;
   localparam int          TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // AHB transfer type codes
   localparam logic [1:0]  HTRANS_IDLE     = 2'h0;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

   // Captured address phase of an AHB transfer
   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [INDEX_BITS-1:0] index;
   } ahb_phase_s;

   // Sticky event set
   typedef struct packed {
      logic rst;
      logic nmi;
   } event_s;

endpackage : watchdog_pkg

// ==== sync3.sv ====
// Three-stage synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
module sync3
   import watchdog_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic asyncIn,
   output logic      syncOut
);

   logic stage1_reg;   // Metastable stage, read only by stage2
   logic stage2_reg;   // Second stage
   logic stage3_reg;   // Third stage

   // Shift chain; first stage feeds nothing but the second
   always_ff @(posedge clk) begin
      if (reset) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // Output follows only when second and third stage agree
   always_ff @(posedge clk) begin
      if (reset) begin
         syncOut <= 1'b0;
      end else if (stage2_reg == stage3_reg) begin
         syncOut <= stage3_reg;
      end
   end

endmodule : sync3

// ==== tick_gen.sv ====
// Divider that makes the one-cycle decrement tick
`timescale 1ns/100ps
module tick_gen
   import watchdog_pkg::*;
#(
   parameter int PERIOD = TICK_CYCLES
)(
   input  wire logic clk,
   input  wire logic reset,
   output logic      tick
);

   logic [31:0] div_reg;   // Cycles elapsed in current period

   // Free-running divider; frozen counter does not stop it
   always_ff @(posedge clk) begin
      if (reset) begin
         div_reg <= 32'h00000000;
         tick    <= 1'b0;
      end else if (div_reg == 32'(PERIOD - 1)) begin
         div_reg <= 32'h00000000;
         tick    <= 1'b1;
      end else begin
         div_reg <= div_reg + 32'h00000001;
         tick    <= 1'b0;
      end
   end

endmodule : tick_gen

// ==== watchdog_timer_nmi_reset.sv ====
// Watchdog down-counter with NMI or system reset, on AHB-Lite
`timescale 1ns/100ps
module watchdog_timer_nmi_reset
   import watchdog_pkg::*;
#(
   parameter int TICK_PERIOD = TICK_CYCLES
)(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        debugHalt,
   output logic             nmiOut,
   output logic             wdogResetOut,
   output logic             irq
);

   // Bus phase and decoded writes
   ahb_phase_s phase_reg;      // Address phase held for data phase
   logic       addrTaken;      // Address phase accepted this edge
   logic       wrCount;        // Data phase write to count
   logic       wrControl;      // Data phase write to control
   logic       wrFrzSet;       // Data phase write to freeze-set
   logic       wrFrzClr;       // Data phase write to freeze-clear
   logic       wrStatus;       // Data phase write to status
   logic       wrMask;         // Data phase write to mask
   logic       keyOpen;        // Key bits of written word all zero
   logic       loadAccept;     // Accepted count reload

   // Counter state
   logic [8:0] cnt_reg;        // Nine-bit two's-complement count
   logic       select_reg;     // Reset-only select bit
   logic       swFreeze_reg;   // Software freeze request
   logic       nmiArmed_reg;   // NMI may still fire for this load
   logic       tick;           // Decrement enable
   logic       haltSync;       // Debug halt after synchroniser
   logic       frozen;         // Counter held this cycle
   logic       tickDec;        // Counter decrements this cycle
   logic       fireNmi;        // NMI threshold reached
   logic       fireRst;        // Reset threshold reached

   // Events
   event_s     status_reg;     // Sticky event bits
   event_s     mask_reg;       // Event enables
   event_s     evtSet;         // Events raised this cycle
   logic [31:0] readData;      // Read mux result

   // Decrement tick from internal divider
   tick_gen #(
      .PERIOD (TICK_PERIOD)
   ) u_tick (
      .clk   (clk),
      .reset (reset),
      .tick  (tick)
   );

   // Debug halt arrives from the processor domain pin
   sync3 u_halt_sync (
      .clk     (clk),
      .reset   (reset),
      .asyncIn (debugHalt),
      .syncOut (haltSync)
   );

   // Slave never stalls and never errors
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase accepted on NONSEQ with bus ready
   assign addrTaken = hsel && hready && (htrans == HTRANS_NONSEQ);

   // Hold the address phase for the following data phase
   always_ff @(posedge clk) begin
      if (reset) begin
         phase_reg <= '0;
      end else if (hready) begin
         phase_reg.valid <= addrTaken;
         phase_reg.write <= hwrite;
         phase_reg.index <= haddr[ADDR_LSB +: INDEX_BITS];
      end
   end

   // Data phase write strobes per register
   always_comb begin
      wrCount   = 1'b0;
      wrControl = 1'b0;
      wrFrzSet  = 1'b0;
      wrFrzClr  = 1'b0;
      wrStatus  = 1'b0;
      wrMask    = 1'b0;
      if (phase_reg.valid && phase_reg.write) begin
         case (phase_reg.index)
            COUNT_INDEX[INDEX_BITS-1:0]:   wrCount   = 1'b1;
            CONTROL_INDEX[INDEX_BITS-1:0]: wrControl = 1'b1;
            FRZ_SET_INDEX[INDEX_BITS-1:0]: wrFrzSet  = 1'b1;
            FRZ_CLR_INDEX[INDEX_BITS-1:0]: wrFrzClr  = 1'b1;
            STATUS_INDEX[INDEX_BITS-1:0]:  wrStatus  = 1'b1;
            MASK_INDEX[INDEX_BITS-1:0]:    wrMask    = 1'b1;
            default: begin
               // Unmapped write is dropped
               wrCount = 1'b0;
            end
         endcase
      end
   end

   // Key filter guards against a runaway program reloading the dog
   assign keyOpen    = (hwdata[KEY_HI:KEY_LO] == KEY_OPEN);
   assign loadAccept = wrCount && keyOpen;

   // Debug halt freezes the decrement in either mode; software freeze only in NMI mode
   assign frozen  = haltSync ||
                    (swFreeze_reg && !select_reg);
   assign tickDec = tick && !frozen;

   // Thresholds; reset reload right away means one pulse per crossing
   assign fireNmi = !select_reg && nmiArmed_reg &&
                    (cnt_reg == CNT_ZERO);
   always_comb begin
      if (select_reg) begin
         fireRst = (cnt_reg == CNT_ZERO) || cnt_reg[SIGN_POS];
      end else begin
         fireRst = (cnt_reg == CNT_MINUS16);
      end
   end

   // Counter: watchdog reset, then software load, then decrement
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= CNT_RESET;
      end else if (fireRst) begin
         cnt_reg <= CNT_RELOAD;
      end else if (loadAccept) begin
         cnt_reg <= hwdata[SIGN_POS:0];
      end else if (tickDec) begin
         cnt_reg <= cnt_reg - CNT_STEP;
      end
   end

   // NMI armed on every reload, disarmed after it fires
   always_ff @(posedge clk) begin
      if (reset) begin
         nmiArmed_reg <= 1'b1;
      end else if (fireRst || loadAccept) begin
         nmiArmed_reg <= 1'b1;
      end else if (fireNmi) begin
         nmiArmed_reg <= 1'b0;
      end
   end

   // Select bit: software may only set it; resets clear it
   always_ff @(posedge clk) begin
      if (reset) begin
         select_reg <= SELECT_RESET;
      end else if (fireRst) begin
         select_reg <= 1'b0;
      end else if (wrControl && hwdata[SELECT_POS]) begin
         select_reg <= 1'b1;
      end
   end

   // Software freeze; set ignored while reset-only mode holds
   always_ff @(posedge clk) begin
      if (reset || fireRst) begin
         swFreeze_reg <= 1'b0;
      end else if (wrFrzSet && hwdata[FREEZE_POS] && !select_reg) begin
         swFreeze_reg <= 1'b1;
      end else if (wrFrzClr && hwdata[FREEZE_POS]) begin
         swFreeze_reg <= 1'b0;
      end
   end

   // Output pulses, registered so they stand one clean cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         nmiOut       <= 1'b0;
         wdogResetOut <= 1'b0;
      end else begin
         nmiOut       <= fireNmi;
         wdogResetOut <= fireRst;
      end
   end

   // Events raised this cycle
   always_comb begin
      evtSet     = '0;
      evtSet.nmi = fireNmi;
      evtSet.rst = fireRst;
   end

   // Sticky status, write one to clear, new event wins over clear
   always_ff @(posedge clk) begin
      if (reset) begin
         status_reg <= '0;
      end else if (wrStatus) begin
         status_reg <= (status_reg & ~event_s'(hwdata[EVT_BITS-1:0]))
                       | evtSet;
      end else begin
         status_reg <= status_reg | evtSet;
      end
   end

   // Interrupt enables
   always_ff @(posedge clk) begin
      if (reset) begin
         mask_reg <= '0;
      end else if (wrMask) begin
         mask_reg <= event_s'(hwdata[EVT_BITS-1:0]);
      end
   end

   // Level interrupt while any unmasked event stands
   assign irq = |(status_reg & mask_reg);

   // Read mux; reserved and key bits read zero
   always_comb begin
      readData = 32'h00000000;
      case (haddr[ADDR_LSB +: INDEX_BITS])
         COUNT_INDEX[INDEX_BITS-1:0]: begin
            readData[SIGN_POS:0] = cnt_reg;
         end
         CONTROL_INDEX[INDEX_BITS-1:0]: begin
            readData[SELECT_POS] = select_reg;
         end
         FRZ_SET_INDEX[INDEX_BITS-1:0]: begin
            readData[FREEZE_POS] = swFreeze_reg;
         end
         FRZ_CLR_INDEX[INDEX_BITS-1:0]: begin
            readData[FREEZE_POS] = swFreeze_reg;
         end
         STATUS_INDEX[INDEX_BITS-1:0]: begin
            readData[EVT_BITS-1:0] = status_reg;
         end
         MASK_INDEX[INDEX_BITS-1:0]: begin
            readData[EVT_BITS-1:0] = mask_reg;
         end
         default: begin
            // Unmapped reads give zero
            readData = 32'h00000000;
         end
      endcase
   end

   // Read data sampled at the address phase, shown in the data phase
   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata <= 32'h00000000;
      end else if (addrTaken && !hwrite) begin
         hrdata <= readData;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_key_filter: assert property (
      wrCount && !keyOpen && !tickDec && !fireRst |=> $stable(cnt_reg))
      else $error("Count changed on a locked write");

   a_load_value: assert property (
      loadAccept && !fireRst |=> cnt_reg == $past(hwdata[8:0]))
      else $error("Accepted write did not load the counter");

   a_read_count: assert property (
      addrTaken && !hwrite && haddr[5:2] == 4'h0
      |=> hrdata == {23'h000000, $past(cnt_reg)})
      else $error("Count read returned wrong value");

   a_count_step: assert property (
      tickDec && !loadAccept && !fireRst
      |=> cnt_reg == $past(cnt_reg) - 9'h001)
      else $error("Counter did not step down by one");

   a_nmi_zero: assert property (
      !select_reg && nmiArmed_reg && cnt_reg == 9'h000 |=> nmiOut)
      else $error("NMI missing at zero");

   a_reset_reload: assert property (
      !select_reg && cnt_reg == 9'h1f0
      |=> wdogResetOut && cnt_reg == 9'h0ff && !select_reg)
      else $error("Reset or reload missing at minus sixteen");

   a_mode_reset: assert property (
      select_reg && (cnt_reg == 9'h000 || cnt_reg[8])
      |=> wdogResetOut && !nmiOut)
      else $error("Reset-only mode did not reset at zero or below");

   a_freeze_ignored: assert property (
      select_reg && !haltSync && tick && !loadAccept && !fireRst
      |=> cnt_reg != $past(cnt_reg))
      else $error("Counter froze in reset-only mode");

   a_freeze_set: assert property (
      wrFrzSet && hwdata[FREEZE_POS] && !select_reg && !fireRst
      |=> swFreeze_reg)
      else $error("Freeze request did not take effect");

   a_select_sticky: assert property (
      select_reg && !fireRst |=> select_reg)
      else $error("Select bit cleared by software");

   a_debug_hold: assert property (
      haltSync && !loadAccept && !fireRst |=> $stable(cnt_reg))
      else $error("Counter moved during debug halt");

   // A reload next to the pulse re-arms legally, so it is left out
   a_pulse_once: assert property (
      nmiOut && !loadAccept && !$past(loadAccept) |=> !nmiOut ##1 !nmiOut)
      else $error("NMI raised twice for one crossing");

   c_nmi_seen:    cover property (nmiOut);
   c_reset_seen:  cover property (wdogResetOut && !$past(select_reg));
   c_mode_reset:  cover property (wdogResetOut && $past(select_reg));
   c_sw_freeze:   cover property (tick && swFreeze_reg && !select_reg);

endmodule : watchdog_timer_nmi_reset

// ==== tb.sv ====
// Self-checking testbench of the watchdog block over AHB-Lite
`timescale 1ns/100ps
module tb
   import watchdog_pkg::*;
;
   localparam int TP = 16;                  // Short tick period for simulation
   localparam logic [31:0] A_CNT = COUNT_INDEX << ADDR_LSB;
   localparam logic [31:0] A_CTL = CONTROL_INDEX << ADDR_LSB;
   localparam logic [31:0] A_FSET = FRZ_SET_INDEX << ADDR_LSB;
   localparam logic [31:0] A_FCLR = FRZ_CLR_INDEX << ADDR_LSB;
   localparam logic [31:0] A_STAT = STATUS_INDEX << ADDR_LSB;
   localparam logic [31:0] A_MASK = MASK_INDEX << ADDR_LSB;
   localparam logic [31:0] A_NONE = 32'h0000003c;  // Unmapped word

   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = HTRANS_IDLE;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;               // Whole words only
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        debugHalt = 1'b1;           // Halted so reset reads are stable
   logic        nmiOut;
   logic        wdogResetOut;
   logic        irq;
   int          n_fail = 0;
   int          n_checks = 0;
   int          cyc = 0;                    // Free-running cycle count
   int          nmiCount = 0;               // High cycles seen on nmiOut
   int          rstCount = 0;               // High cycles seen on reset request
   int          nmiCyc = 0;
   int          rstCyc = 0;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   always #25 clk = ~clk;

   watchdog_timer_nmi_reset #(.TICK_PERIOD(TP)) u_watchdog_timer_nmi_reset (
      .clk          (clk),
      .reset        (reset),
      .hsel         (hsel),
      .haddr        (haddr),
      .htrans       (htrans),
      .hwrite       (hwrite),
      .hsize        (hsize),
      .hwdata       (hwdata),
      .hready       (hready),
      .hreadyout    (hreadyout),
      .hresp        (hresp),
      .hrdata       (hrdata),
      .debugHalt    (debugHalt),
      .nmiOut       (nmiOut),
      .wdogResetOut (wdogResetOut),
      .irq          (irq)
   );

   // Pulse monitor; counting high cycles also catches pulses that linger
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (nmiOut === 1'b1) begin
         nmiCount <= nmiCount + 1;
         nmiCyc   <= cyc;
      end
      if (wdogResetOut === 1'b1) begin
         rstCount <= rstCount + 1;
         rstCyc   <= cyc;
      end
   end

   // Value comparison, counted
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One AHB-Lite single write; entered just after a rising edge
   task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask : bus_write

   // One AHB-Lite single read; data taken at the data-phase edge
   task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= 1'b0;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= HTRANS_IDLE;
      do @(posedge clk); while (hready !== 1'b1);
      d = hrdata;
      check("hresp", 32'h0, {31'h0, hresp});
   endtask : bus_read

   // Read a register and compare it
   task automatic expect_reg(input string what, input logic [31:0] a,
                             input logic [31:0] exp);
      logic [31:0] v;
      bus_read(a, v);
      check(what, exp, v);
   endtask : expect_reg

   // Counter drop over exactly ten tick periods between two captures
   task automatic rate_check(input string what, input logic [8:0] drop);
      logic [31:0] r1;
      logic [31:0] r2;
      bus_read(A_CNT, r1);
      repeat (TP * 10 - 2) @(posedge clk);
      bus_read(A_CNT, r2);
      check(what, {23'h0, drop}, {23'h0, r1[8:0] - r2[8:0]});
   endtask : rate_check

   // Bounded wait for a new pulse of either output
   task automatic wait_event(input bit isRst, input int lim);
      int start;
      start = isRst ? rstCount : nmiCount;
      for (int i = 0; i < lim && start == (isRst ? rstCount : nmiCount); i++)
         @(posedge clk);
      check("event seen", 32'h0,
            {31'h0, start == (isRst ? rstCount : nmiCount)});
   endtask : wait_event

   // Apply reset for six cycles, leaving off just after an edge
   task automatic do_reset();
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
   endtask : do_reset

   // Verdict; the only place the run ends
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   // Hang guard, well beyond the expected run of about 1200 cycles
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      final_report();
   end

   // Main test sequence
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      expect_reg("count", A_CNT, 32'h000000ff);
      expect_reg("control", A_CTL, 32'h0);
      expect_reg("status", A_STAT, 32'h0);
      expect_reg("mask", A_MASK, 32'h0);
      $display("test reset_values done");
      // Key bits guard the load; sign bit travels with the value
      bus_write(A_CNT, 32'h00000203);
      expect_reg("count", A_CNT, 32'h000000ff);
      bus_write(A_CNT, 32'h00000105);
      expect_reg("count", A_CNT, 32'h00000105);
      bus_write(A_CNT, 32'h00008003);
      expect_reg("count", A_CNT, 32'h00000105);
      rate_check("halted drop", 9'h000);
      $display("test load_guard done");
      // Software freeze and resume with select clear
      debugHalt <= 1'b0;
      bus_write(A_FSET, 32'h00000008);
      bus_write(A_FSET, 32'h00000000);
      expect_reg("freeze", A_FSET, 32'h00000008);
      rate_check("frozen drop", 9'h000);
      bus_write(A_FCLR, 32'h00000000);
      expect_reg("freeze", A_FCLR, 32'h00000008);
      bus_write(A_FCLR, 32'h00000008);
      expect_reg("freeze", A_FCLR, 32'h00000000);
      rate_check("running drop", 9'h00a);
      $display("test freeze done");
      // NMI at zero, wrap, reset at minus sixteen, status and irq
      bus_write(A_MASK, 32'h00000003);
      bus_write(A_CNT, 32'h00000002);
      wait_event(1'b0, TP * 3 + 8);
      repeat (20) @(posedge clk);
      expect_reg("count", A_CNT, 32'h000001ff);
      check("irq", 32'h1, {31'h0, irq});
      expect_reg("status", A_STAT, 32'h00000001);
      wait_event(1'b1, TP * 16 + 8);
      expect_reg("count", A_CNT, 32'h000000ff);
      check("reset gap", TP * 16, rstCyc - nmiCyc);
      check("nmi pulses", 32'h1, nmiCount);
      check("reset pulses", 32'h1, rstCount);
      expect_reg("status", A_STAT, 32'h00000003);
      bus_write(A_STAT, 32'h00000001);
      expect_reg("status", A_STAT, 32'h00000002);
      check("irq", 32'h1, {31'h0, irq});
      bus_write(A_MASK, 32'h00000001);
      expect_reg("status", A_STAT, 32'h00000002);
      check("irq", 32'h0, {31'h0, irq});
      bus_write(A_STAT, 32'h00000002);
      expect_reg("status", A_STAT, 32'h0);
      $display("test nmi_reset done");
      // Reset-only mode: set-only select, no freeze, early reset
      bus_write(A_CTL, 32'h00000001);
      bus_write(A_CTL, 32'h00000000);
      expect_reg("control", A_CTL, 32'h00000001);
      bus_write(A_FSET, 32'h00000008);
      expect_reg("freeze", A_FSET, 32'h0);
      debugHalt <= 1'b1;
      repeat (6) @(posedge clk);
      rate_check("halted drop", 9'h000);
      debugHalt <= 1'b0;
      repeat (6) @(posedge clk);
      rate_check("no freeze drop", 9'h00a);
      for (int i = 0; i < 2; i++) begin
         bus_write(A_CTL, 32'h00000001);
         bus_write(A_CNT, i == 0 ? 32'h00000000 : 32'h000001f5);
         wait_event(1'b1, 6);
         expect_reg("control", A_CTL, 32'h0);
      end
      check("nmi pulses", 32'h1, nmiCount);
      $display("test reset_only done");
      // Unmapped word: write dropped, read zero
      bus_write(A_NONE, 32'hffffffff);
      expect_reg("unmapped", A_NONE, 32'h0);
      $display("test unmapped done");
      // Reset input pulsed in mid-run clears select and reloads count
      bus_write(A_CTL, 32'h00000001);
      debugHalt <= 1'b1;
      do_reset();
      expect_reg("count", A_CNT, 32'h000000ff);
      expect_reg("control", A_CTL, 32'h0);
      $display("test second_reset done");
      final_report();
   end

endmodule : tb
